// file: thd_monitor.sv
// The Wishbone register port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
module thd_monitor
    import thd_pkg::*;
#(
    parameter int MS_DIV = MS_CYCLES
) (
    input  wire logic             mclk_in,
    input  wire logic             rst_in,
    input  wire logic             ce_in,
    input  wire logic             wb_cyc_in,
    input  wire logic             wb_stb_in,
    input  wire logic             wb_we_in,
    input  wire logic [7:0]       wb_adr_in,
    input  wire logic [3:0]       wb_sel_in,
    input  wire logic [31:0]      wb_dat_in,
    output logic      [31:0]      wb_dat_out,
    output logic                  wb_ack_out,
    input  wire thd_spec_s        spec_in,
    input  wire logic             block_in,
    input  wire logic [2:0]       group_sel_in,
    output logic      [NUM_GRP-1:0] start_out,
    output logic      [NUM_GRP-1:0] alarm_out,
    output logic      [NUM_GRP-1:0] blocked_out,
    output thd_evt_s              evt_out,
    output logic                  irq_out
);
    localparam logic [2:0] HARM_FUND = 3'h1;

    logic                 amp_reg, amp_next;
    logic [2:0]           en_reg, en_next;
    logic                 clr_cnt;
    logic [31:0]          set_a_reg [NUM_SET];
    logic [31:0]          set_a_next [NUM_SET];
    logic [31:0]          set_b_reg [NUM_SET];
    logic [31:0]          set_b_next [NUM_SET];
    logic [2:0]           grp_reg, grp_next;
    logic [NUM_OUT-1:0]   irq_st_reg, irq_st_next, irq_mask_reg, irq_mask_next;
    logic [31:0]          rdat_reg, rdat_next;
    logic                 ack_reg, ack_next;
    logic                 wr_go;
    logic [31:0]          presc_reg, presc_next, ms_reg, ms_next;
    logic                 ms_tick;
    logic [SQ_W-1:0]      fund_reg, fund_next;
    logic [SUM_W-1:0]     sum_reg, sum_next;
    logic [NUM_CHAN-1:0]  pick_reg, pick_next;
    logic [NUM_OUT-1:0]   outs, prev_reg;
    thd_evt_s             evt_reg, evt_next;
    logic [15:0]          cnt_reg [NUM_OUT];
    logic [15:0]          cnt_next [NUM_OUT];

    // Byte-lane merge for register writes
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                          input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                r[8*b +: 8] = wd[8*b +: 8];
            end
        end
        return r;
    endfunction

    // Ack one cycle after request; write lands at the acked edge
    assign wr_go = wb_cyc_in & wb_stb_in & wb_we_in & ack_reg;
    assign clr_cnt = wr_go & wb_sel_in[0] & (wb_adr_in == ADDR_CTRL)
                     & wb_dat_in[CTRL_CLR_BIT];
    assign wb_ack_out = ack_reg;
    assign wb_dat_out = rdat_reg;
    assign irq_out = |(irq_st_reg & irq_mask_reg);

    // Bus decode, settings and interrupt bookkeeping
    always_comb begin
        logic [3:0] idx;
        idx = 4'h0;
        ack_next = wb_cyc_in & wb_stb_in & ~ack_reg;
        amp_next = amp_reg;
        en_next = en_reg;
        irq_mask_next = irq_mask_reg;
        irq_st_next = irq_st_reg;
        rdat_next = rdat_reg;
        set_a_next = set_a_reg;
        set_b_next = set_b_reg;
        if (wr_go && wb_adr_in == ADDR_CTRL && wb_sel_in[0]) begin
            amp_next = wb_dat_in[CTRL_AMP_BIT];
            en_next = wb_dat_in[CTRL_EN_LSB +: 3];
        end
        if (wr_go && wb_adr_in == ADDR_IRQ_MASK) begin
            irq_mask_next = NUM_OUT'(merge(32'(irq_mask_reg), wb_dat_in, wb_sel_in));
        end
        if (wr_go && wb_adr_in == ADDR_IRQ_STAT) begin
            irq_st_next = irq_st_reg & ~NUM_OUT'(wb_dat_in & merge(32'h0, 32'hFFFFFFFF,
                                                                    wb_sel_in));
        end
        irq_st_next = irq_st_next | (outs & ~prev_reg); // Set wins over clear
        if (wr_go && wb_adr_in >= ADDR_SET_BASE && wb_adr_in < ADDR_CNT_BASE) begin
            idx = 4'(wb_adr_in[5:2]);
            if (idx[0]) begin
                set_b_next[idx[3:1]] = merge(set_b_reg[idx[3:1]], wb_dat_in, wb_sel_in);
            end else begin
                set_a_next[idx[3:1]] = merge(set_a_reg[idx[3:1]], wb_dat_in, wb_sel_in);
            end
        end
        if (ack_next && !wb_we_in) begin
            idx = 4'(wb_adr_in[5:2]);
            case (wb_adr_in)
                ADDR_CTRL:     rdat_next = {27'h0, 1'b0, en_reg, amp_reg};
                ADDR_STATUS:   rdat_next = {13'h0, grp_reg, 7'h0, outs};
                ADDR_IRQ_STAT: rdat_next = {23'h0, irq_st_reg};
                ADDR_IRQ_MASK: rdat_next = {23'h0, irq_mask_reg};
                ADDR_TIME:     rdat_next = ms_reg;
                default: begin
                    if (wb_adr_in >= ADDR_SET_BASE && wb_adr_in < ADDR_CNT_BASE) begin
                        rdat_next = idx[0] ? set_b_reg[idx[3:1]] : set_a_reg[idx[3:1]];
                    end else if (wb_adr_in >= ADDR_CNT_BASE && idx < 4'(NUM_OUT)
                                 && wb_adr_in[7:6] == 2'h2) begin
                        rdat_next = {16'h0, cnt_reg[idx]};
                    end else begin
                        rdat_next = 32'h0;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            ack_reg <= 1'b0;
            amp_reg <= CTRL_AMP_RST;
            en_reg <= CTRL_EN_RST;
            irq_mask_reg <= '0;
            irq_st_reg <= '0;
            rdat_reg <= 32'h0;
            for (int g = 0; g < NUM_SET; g++) begin
                set_a_reg[g] <= {THR_RST, THR_RST};
                set_b_reg[g] <= {DELAY_RST, THR_RST};
            end
        end else if (ce_in) begin
            ack_reg <= ack_next;
            amp_reg <= amp_next;
            en_reg <= en_next;
            irq_mask_reg <= irq_mask_next;
            irq_st_reg <= irq_st_next;
            rdat_reg <= rdat_next;
            set_a_reg <= set_a_next;
            set_b_reg <= set_b_next;
        end
    end

    // Millisecond time base and group selection
    always_comb begin
        ms_tick = (presc_reg == 32'(MS_DIV - 1));
        presc_next = ms_tick ? 32'h0 : presc_reg + 32'h1;
        ms_next = ms_tick ? ms_reg + 32'h1 : ms_reg;
        grp_next = (|en_reg) ? group_sel_in : grp_reg;
    end

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            presc_reg <= 32'h0;
            ms_reg <= 32'h0;
            grp_reg <= 3'h0;
        end else if (ce_in) begin
            presc_reg <= presc_next;
            ms_reg <= ms_next;
            grp_reg <= grp_next;
        end
    end

    // Harmonic accumulation and threshold comparison per channel
    always_comb begin
        logic [SQ_W-1:0]  sq;
        logic [15:0]      thr;
        logic [15:0]      thr97;
        logic [CMP_W-1:0] lhs, rhs_up, rhs_dn;
        sq = SQ_W'(spec_in.mag) * SQ_W'(spec_in.mag);
        fund_next = fund_reg;
        sum_next = sum_reg;
        pick_next = pick_reg;
        thr = (spec_in.chan < 3'h3) ? set_a_reg[grp_reg][15:0] :
              (spec_in.chan == 3'h3) ? set_a_reg[grp_reg][31:16] : set_b_reg[grp_reg][15:0];
        thr97 = 16'((32'(thr) * 32'(REL_PCT)) / 32'd100);
        lhs = '0;
        rhs_up = '0;
        rhs_dn = '0;
        if (spec_in.valid && spec_in.harm == 5'(HARM_FUND)) begin
            fund_next = sq;
            sum_next = '0;
        end else if (spec_in.valid && spec_in.harm >= 5'h2) begin
            sum_next = sum_reg + SUM_W'(sq);
        end
        if (spec_in.valid && spec_in.harm == 5'(LAST_HARM) && spec_in.chan < 3'(NUM_CHAN)) begin
            if (amp_reg) begin
                // Square both sides to avoid a root
                lhs = CMP_W'(sum_next) * CMP_W'(PCT_SCALE) * CMP_W'(PCT_SCALE);
                rhs_up = CMP_W'(thr) * CMP_W'(thr) * CMP_W'(fund_reg);
                rhs_dn = CMP_W'(thr97) * CMP_W'(thr97) * CMP_W'(fund_reg);
            end else begin
                lhs = CMP_W'(sum_next) * CMP_W'(PCT_SCALE);
                rhs_up = CMP_W'(thr) * CMP_W'(fund_reg);
                rhs_dn = CMP_W'(thr97) * CMP_W'(fund_reg);
            end
            if (lhs > rhs_up) begin
                pick_next[spec_in.chan] = 1'b1;
            end else if (lhs < rhs_dn) begin
                pick_next[spec_in.chan] = 1'b0;
            end
        end
    end

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            fund_reg <= '0;
            sum_reg <= '0;
            pick_reg <= '0;
        end else if (ce_in) begin
            fund_reg <= fund_next;
            sum_reg <= sum_next;
            pick_reg <= pick_next;
        end
    end

    // Blocking, delay and outputs for each channel group
    for (genvar g = 0; g < NUM_GRP; g++) begin : grp
        logic        pick, st_reg, st_next, al_reg, al_next, bl_reg, bl_next;
        logic [15:0] dly_reg, dly_next;
        assign pick = (g == 0) ? |pick_reg[2:0] : pick_reg[g + 2];
        always_comb begin
            st_next = pick & en_reg[g] & ~block_in;
            bl_next = pick & en_reg[g] & block_in;
            dly_next = dly_reg;
            if (!st_next) begin
                dly_next = 16'h0;
            end else if (ms_tick && dly_reg < set_b_reg[grp_reg][31:16]) begin
                dly_next = dly_reg + 16'h1;
            end
            al_next = st_next & st_reg & (dly_reg >= set_b_reg[grp_reg][31:16]);
        end
        always_ff @(posedge mclk_in) begin
            if (rst_in) begin
                st_reg <= 1'b0;
                al_reg <= 1'b0;
                bl_reg <= 1'b0;
                dly_reg <= 16'h0;
            end else if (ce_in) begin
                st_reg <= st_next;
                al_reg <= al_next;
                bl_reg <= bl_next;
                dly_reg <= dly_next;
            end
        end
        assign start_out[g] = st_reg;
        assign alarm_out[g] = al_reg;
        assign blocked_out[g] = bl_reg;
    end

    assign outs = {blocked_out, alarm_out, start_out};

    // Edge events and occurrence counters
    always_comb begin
        evt_next.valid = |(outs ^ prev_reg);
        evt_next.which = outs ^ prev_reg;
        evt_next.level = outs;
        evt_next.stamp = ms_reg;
        for (int i = 0; i < NUM_OUT; i++) begin
            cnt_next[i] = clr_cnt ? 16'h0 : cnt_reg[i];
            if (outs[i] && !prev_reg[i]) begin
                cnt_next[i] = cnt_next[i] + 16'h1;
            end
        end
    end

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            prev_reg <= '0;
            evt_reg <= '0;
            for (int i = 0; i < NUM_OUT; i++) begin
                cnt_reg[i] <= 16'h0;
            end
        end else if (ce_in) begin
            prev_reg <= outs;
            evt_reg <= evt_next;
            cnt_reg <= cnt_next;
        end
    end

    assign evt_out = evt_reg;
endmodule

// file: thd_pkg.sv
package thd_pkg;
    // Channel and output counts
    localparam int NUM_CHAN   = 5;
    localparam int NUM_GRP    = 3;
    localparam int NUM_OUT    = 9;
    localparam int NUM_SET    = 8;
    localparam int LAST_HARM  = 31;
    localparam int MAG_W      = 16;
    localparam int SQ_W       = 2 * MAG_W;
    localparam int SUM_W      = SQ_W + 5;
    localparam int CMP_W      = 72;

    // Timing: stamp resolution of 1 ms at 40 MHz
    localparam int CLK_HZ        = 40_000_000;
    localparam int STAMP_RES_MS  = 1;
    localparam int MS_CYCLES     = CLK_HZ / 1000 * STAMP_RES_MS;

    // Ratio scaling: thresholds in 0.01 % units, release at 97 %
    localparam int PCT_SCALE     = 10000;
    localparam int REL_PCT       = 97;

    // Register byte addresses
    localparam logic [7:0] ADDR_CTRL     = 8'h00;
    localparam logic [7:0] ADDR_STATUS   = 8'h04;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h0C;
    localparam logic [7:0] ADDR_TIME     = 8'h10;
    localparam logic [7:0] ADDR_SET_BASE = 8'h40;
    localparam logic [7:0] ADDR_CNT_BASE = 8'h80;

    // Control field positions
    localparam int CTRL_AMP_BIT  = 0;
    localparam int CTRL_EN_LSB   = 1;
    localparam int CTRL_CLR_BIT  = 4;
    localparam int STAT_GRP_LSB  = 16;

    // Reset values
    localparam logic        CTRL_AMP_RST = 1'b1;
    localparam logic [2:0]  CTRL_EN_RST  = 3'h7;
    localparam logic [15:0] THR_RST      = 16'h03E8;
    localparam logic [15:0] DELAY_RST    = 16'h0064;

    // Spectrum sample from the measurement stage
    typedef struct packed {
        logic             valid;
        logic [2:0]       chan;
        logic [4:0]       harm;
        logic [MAG_W-1:0] mag;
    } thd_spec_s;

    // Output change event with millisecond stamp
    typedef struct packed {
        logic               valid;
        logic [NUM_OUT-1:0] which;
        logic [NUM_OUT-1:0] level;
        logic [31:0]        stamp;
    } thd_evt_s;
endpackage

// file: thd_spec_src.sv
`timescale 1ns/1ps
module thd_spec_src
    import thd_pkg::*;
(
    input  wire logic        mclk_in,
    input  wire logic        go_in,
    input  wire logic [2:0]  chan_in,
    input  wire logic [15:0] harm_in,
    output logic             busy_out,
    output thd_spec_s        spec_out
);
    logic [5:0] step_reg = 6'h00;

    initial spec_out = '0;

    // One spectrum per channel, fundamental first then harmonics back to back
    always @(posedge mclk_in) begin
        if (step_reg != 6'h00 && step_reg <= 6'h1F) begin
            spec_out.valid <= 1'b1;
            spec_out.chan  <= chan_in;
            spec_out.harm  <= step_reg[4:0];
            spec_out.mag   <= (step_reg == 6'h01) ? 16'h03E8 : harm_in;
            step_reg       <= step_reg + 6'h01;
        end else begin
            // Idle lines toggle so stale data never looks valid
            spec_out.valid <= 1'b0;
            spec_out.chan  <= ~spec_out.chan;
            spec_out.mag   <= ~spec_out.mag;
            step_reg       <= go_in ? 6'h01 : 6'h00;
        end
    end

    assign busy_out = (step_reg != 6'h00);
endmodule

// file: thd_monitor_properties.sv
`timescale 1ns/1ps
module thd_monitor_properties
    import thd_pkg::*;
(
    input wire logic               mclk_in,
    input wire logic               rst_in,
    input wire logic               block_in,
    input wire logic [NUM_GRP-1:0] start_out,
    input wire logic [NUM_GRP-1:0] alarm_out,
    input wire logic [NUM_GRP-1:0] blocked_out,
    input wire thd_evt_s           evt_out
);
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (rst_in);

    // Blocking steers pick-up away from start
    property p_excl; (start_out & blocked_out) == '0; endproperty
    a_excl: assert property (p_excl)
        else $error("start and blocked together");
    property p_blk; block_in [*2] |-> start_out == '0; endproperty
    a_blk: assert property (p_blk)
        else $error("start while blocked");
    property p_noblk; !block_in [*2] |-> blocked_out == '0; endproperty
    a_noblk: assert property (p_noblk)
        else $error("blocked without block");
    // Alarm follows a held start
    property p_alm; $rose(alarm_out[0]) |-> $past(start_out[0]) && start_out[0]; endproperty
    a_alm: assert property (p_alm)
        else $error("alarm without start");
    property p_alm_clr; $fell(start_out[0]) |-> ##[0:1] !alarm_out[0]; endproperty
    a_alm_clr: assert property (p_alm_clr)
        else $error("alarm outlives start");
    // Output edges produce events
    property p_ev_on; $rose(start_out[0]) |=> evt_out.valid && evt_out.which[0] && evt_out.level[0]; endproperty
    a_ev_on: assert property (p_ev_on)
        else $error("no on event");
    property p_ev_off; $fell(start_out[0]) |=> evt_out.valid && evt_out.which[0] && !evt_out.level[0]; endproperty
    a_ev_off: assert property (p_ev_off)
        else $error("no off event");
    property p_ev_blk; $rose(blocked_out[1]) |=> evt_out.valid && evt_out.which[7]; endproperty
    a_ev_blk: assert property (p_ev_blk)
        else $error("no blocked event");
endmodule

bind thd_monitor thd_monitor_properties i_props (.mclk_in(mclk_in), .rst_in(rst_in),
    .block_in(block_in), .start_out(start_out), .alarm_out(alarm_out),
    .blocked_out(blocked_out), .evt_out(evt_out));

// file: tb.sv
`timescale 1ns/1ps
module tb;
    import thd_pkg::*;
    localparam int MSD = 20;
    logic        mclk_in = 0, rst_in = 1, cyc = 0, we = 0, go = 0, blk = 0, ce = 1;
    logic        ack, irq, busy;
    logic [7:0]  adr = 8'h00;
    logic [31:0] wdat = 32'h00000000, rdat, rd;
    logic [2:0]  gsel = 3'h0, ch = 3'h0, st, al, bl, pk = 3'h0;
    logic [15:0] hm = 16'h0000;
    thd_spec_s   spec;
    thd_evt_s    evt;
    int          err_count = 0, samples_checked = 0, seed = 85772, cyc_n = 0, m, n;
    int          p[5] = '{0, 0, 0, 0, 0};
    int          cnt0 = 0;
    int          tab[2][4] = '{'{58, 57, 56, 57}, '{19, 18, 17, 18}};

    thd_monitor #(.MS_DIV(MSD)) i_dut (.mclk_in(mclk_in), .rst_in(rst_in), .ce_in(ce),
        .wb_cyc_in(cyc), .wb_stb_in(cyc), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(4'hF),
        .wb_dat_in(wdat), .wb_dat_out(rdat), .wb_ack_out(ack), .spec_in(spec),
        .block_in(blk), .group_sel_in(gsel), .start_out(st), .alarm_out(al),
        .blocked_out(bl), .evt_out(evt), .irq_out(irq));
    thd_spec_src i_src (.mclk_in(mclk_in), .go_in(go), .chan_in(ch), .harm_in(hm),
        .busy_out(busy), .spec_out(spec));

    // Clock and hang guard
    always #12.5 mclk_in = ~mclk_in;
    always @(posedge mclk_in) begin
        cyc_n <= cyc_n + 1;
        if (cyc_n == 30000) begin
            err_count++;
            end_sim();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk_in);
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do @(posedge mclk_in); while (ack !== 1'b1);
        rd = rdat;
        cyc <= 1'b0;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h00000000);
        chk(rd, e);
    endtask
    // Distortion in 0.01 % units with a fundamental of 1000
    function automatic int ratio(int md, int hv);
        int r;
        r = 0;
        if (md == 0) return 30 * hv * hv / 100;
        while ((r + 1) * (r + 1) <= 3000 * hv * hv) r++;
        return r;
    endfunction
    task automatic frame(input int c, input int hv);
        @(posedge mclk_in);
        ch <= c[2:0];
        hm <= hv[15:0];
        go <= 1'b1;
        @(posedge mclk_in);
        go <= 1'b0;
        do @(posedge mclk_in); while (busy !== 1'b0);
        repeat (3) @(posedge mclk_in);
        n = ratio(m, hv);
        p[c] = (n > 1000) ? 1 : (n < 970) ? p[c] & 0 : p[c];
        if ((p[0] | p[1] | p[2]) && !pk[0] && !blk) cnt0++;
        pk = {p[4][0], p[3][0], p[0][0] | p[1][0] | p[2][0]};
        chk(st, pk & {3{~blk}});
        chk(bl, pk & {3{blk}});
    endtask
    task automatic end_sim();
        if (err_count == 0 && samples_checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    initial begin
        repeat (6) @(posedge mclk_in);
        rst_in <= 1'b0;
        rchk(ADDR_CTRL, 32'h0000000F);
        rchk(ADDR_SET_BASE, 32'h03E803E8);
        rchk(ADDR_SET_BASE + 8'h04, 32'h006403E8);
        rchk(8'h3C, 32'h00000000);
        // Hysteresis table in both modes
        for (m = 1; m >= 0; m--) begin
            wb(1'b1, ADDR_CTRL, 32'h0000000E | m);
            for (int k = 0; k < 4; k++) frame(0, tab[m][k]);
        end
        // Random channels, modes and harmonic levels
        repeat (16) begin
            m = $unsigned($random(seed)) % 2;
            wb(1'b1, ADDR_CTRL, 32'h0000000E | m);
            frame($unsigned($random(seed)) % 5, $unsigned($random(seed)) % 64);
        end
        // Alarm delay of 3 ms, then counters and their clearing
        m = 1;
        wb(1'b1, ADDR_CTRL, 32'h0000000F);
        for (int c = 0; c < 5; c++) frame(c, 0);
        wb(1'b1, ADDR_SET_BASE + 8'h04, 32'h000303E8);
        frame(0, 19);
        n = 0;
        while (al[0] !== 1'b1 && n < 200) begin
            @(posedge mclk_in);
            n++;
        end
        chk(n >= 2 * MSD - 4 && n <= 3 * MSD + 4, 1);
        frame(0, 0);
        chk(al[0], 0);
        rchk(ADDR_CNT_BASE, cnt0);
        rchk(ADDR_CNT_BASE + 8'h0C, 1);
        wb(1'b1, ADDR_CTRL, 32'h0000001F);
        rchk(ADDR_CNT_BASE, 0);
        // Pick-up under block, then block removed
        blk <= 1'b1;
        frame(3, 19);
        blk <= 1'b0;
        repeat (2) @(posedge mclk_in);
        chk(st, pk);
        chk(bl, 0);
        // Blocked off and start on give one stamped event
        @(posedge mclk_in);
        chk({evt.valid, evt.which, evt.level}, {1'b1, 9'h082, 9'h002});
        n = evt.stamp;
        wb(1'b0, ADDR_TIME, 32'h00000000);
        chk(rd - n <= 1, 1);
        // Interrupt masked, unmasked and cleared
        #1 chk(irq, 0);
        wb(1'b1, ADDR_IRQ_MASK, 32'h00000002);
        #1 chk(irq, 1);
        wb(1'b1, ADDR_IRQ_STAT, 32'h00000002);
        #1 chk(irq, 0);
        // Set selection follows only while alarming is enabled
        gsel <= 3'h5;
        wb(1'b1, ADDR_CTRL, 32'h00000001);
        gsel <= 3'h2;
        wb(1'b0, ADDR_STATUS, 32'h00000000);
        chk(rd[18:16], 5);
        // Clock enable low freezes the time base
        wb(1'b0, ADDR_TIME, 32'h00000000);
        n = rd;
        ce <= 1'b0;
        repeat (5 * MSD) @(posedge mclk_in);
        ce <= 1'b1;
        wb(1'b0, ADDR_TIME, 32'h00000000);
        chk(rd - n <= 1, 1);
        end_sim();
    end
endmodule
